/* File: design/tpc_counter.sv */
// module: up-down position counter with busy, direction, wrap and bus output
// -----------------------------------------------------------------------------
// Overview of operation
// - two select inputs pick 10, 12, 14 or 16 bit word width
// - no convert command; count steps one LSB per tracking step
// - one busy pulse per single LSB count change
// - count appears as unsigned natural binary on the position lines
// - wrap pulse on rollover all ones to zeros or reverse
// - direction flag latched, changes only on reversal with one LSB step
// - direction settles before the matching wrap pulse
// - wrap and direction unaffected by latch hold
// - counts two to the resolution per revolution
// - hold low freezes latches; release gives refresh busy pulse
// - lines driven only while output enable low, else high impedance
// - byte choice high puts the whole word on the lines; low puts LSB byte on both halves
// - unused lines low below 16 bits while byte choice high
module tpc_counter
  import tpc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // tracking loop steps
  input wire tpc_step_s step,
  // resolution select
  input wire logic resolution_select_low,
  input wire logic resolution_select_high,
  // host bus controls
  input wire logic latch_hold_n,
  input wire logic output_enable_n,
  input wire logic byte_choice,
  // status outputs
  output logic busy,
  output logic direction,
  output logic wrap,
  output logic step_ready,
  // position lines, enable low means driven
  output logic [15:0] position_lines,
  output logic [15:0] position_lines_oe_n
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  tpc_state_e state_q;
  logic [15:0] count_q;
  logic [15:0] latch_q;
  logic [4:0] busy_cnt_q;
  logic [5:0] wrap_cnt_q;
  logic hold_q;
  logic refresh_q;
  logic dir_up;
  logic take_step;
  logic [15:0] mask;
  logic [15:0] count_d;
  logic at_top;
  logic at_zero;
  logic [15:0] word;
  logic [15:0] shown;
  logic carry_q;
  logic arm_q;

  // width mask from the select code
  function automatic logic [15:0] res_mask(input logic [1:0] sel);
    case (sel)
      TPC_RES_10: res_mask = 16'h03ff;
      TPC_RES_12: res_mask = 16'h0fff;
      TPC_RES_14: res_mask = 16'h3fff;
      default: res_mask = 16'hffff;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // step decode
  // ---------------------------------------------------------------------------
  assign mask = res_mask({resolution_select_high, resolution_select_low});
  assign take_step = (state_q == TPC_IDLE) && (step.up ^ step.down);
  assign dir_up = step.up;
  assign at_top = ((count_q & mask) == mask);
  assign at_zero = ((count_q & mask) == 16'h0000);
  // step by one and fold back into the selected width
  always_comb begin
    if (dir_up) begin
      count_d = (count_q + 16'h0001) & mask;
    end else begin
      count_d = (count_q - 16'h0001) & mask;
    end
  end

  // sequencer: step is taken, two cycles later busy rises
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= TPC_IDLE;
    end else begin
      case (state_q)
        TPC_IDLE: begin
          if (take_step || refresh_q) begin
            state_q <= TPC_STEP;
          end
        end
        TPC_STEP: state_q <= TPC_BUSY;
        TPC_BUSY: begin
          if (busy_cnt_q == 5'h01) begin
            state_q <= TPC_IDLE;
          end
        end
        default: state_q <= TPC_IDLE;
      endcase
    end
  end

  // direction latched at the step, ahead of data, busy and wrap
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      direction <= 1'b1;
    end else if (take_step) begin
      direction <= dir_up;
    end
  end

  // up-down counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= TPC_POS_RST;
    end else if (take_step) begin
      count_q <= count_d;
    end
  end

  // ---------------------------------------------------------------------------
  // pulse pipeline
  // ---------------------------------------------------------------------------
  // the carry waits one edge so direction leads wrap,
  // and the busy start waits one more so wrap leads busy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      carry_q <= 1'b0;
      arm_q <= 1'b0;
    end else begin
      carry_q <= take_step && ((dir_up && at_top) || (!dir_up && at_zero));
      arm_q <= (state_q == TPC_STEP);
    end
  end

  // busy pulse: one per count change and one per hold release
  // starts two edges after the step, behind direction and wrap
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      busy_cnt_q <= 5'h00;
    end else if (arm_q) begin
      busy <= 1'b1;
      busy_cnt_q <= TPC_BUSY_LEN;
    end else if (busy_cnt_q != 5'h00) begin
      busy_cnt_q <= busy_cnt_q - 5'h01;
      busy <= (busy_cnt_q != 5'h01);
    end else begin
      busy <= 1'b0;
    end
  end

  // wrap pulse on major carry, one cycle after direction settles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrap <= 1'b0;
      wrap_cnt_q <= 6'h00;
    end else if (carry_q) begin
      wrap <= 1'b1;
      wrap_cnt_q <= TPC_WRAP_LEN;
    end else if (wrap_cnt_q != 6'h00) begin
      wrap_cnt_q <= wrap_cnt_q - 6'h01;
      wrap <= (wrap_cnt_q != 6'h01);
    end else begin
      wrap <= 1'b0;
    end
  end

  // hold tracking and refresh request on release
  // a release in the cycle that clears the request wins, so no refresh is lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_q <= 1'b0;
      refresh_q <= 1'b0;
    end else begin
      hold_q <= !latch_hold_n;
      if (hold_q && latch_hold_n) begin
        refresh_q <= 1'b1;
      end else if (state_q == TPC_IDLE && !take_step) begin
        refresh_q <= 1'b0;
      end
    end
  end

  // output latches follow the counter unless held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latch_q <= TPC_POS_RST;
    end else if (latch_hold_n) begin
      latch_q <= count_q & mask;
    end
  end

  // ---------------------------------------------------------------------------
  // bus output
  // ---------------------------------------------------------------------------
  // bit 15 is line 1 (MSB); low byte of lines is the upper eight lines
  // mask again at the pins so a narrower select never shows stale upper bits
  assign shown = latch_q & mask;
  assign word = byte_choice ? {shown[15:8], shown[7:0]}
                            : {shown[7:0], shown[7:0]};
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      position_lines <= 16'h0000;
      position_lines_oe_n <= 16'hffff;
      step_ready <= 1'b0;
    end else begin
      position_lines <= word;
      position_lines_oe_n <= {16{output_enable_n}};
      step_ready <= (state_q == TPC_IDLE) && !take_step && !refresh_q;
    end
  end

endmodule // tpc_counter

/* File: design/tpc_pkg.sv */
// package: constants and types for the tracking position counter output block
package tpc_pkg;

  // ---------------------------------------------------------------------------
  // widths and resolution codes
  // ---------------------------------------------------------------------------
  localparam int unsigned TPC_POS_W = 16;
  localparam int unsigned TPC_BYTE_W = 8;
  localparam logic [1:0] TPC_RES_10 = 2'h0;
  localparam logic [1:0] TPC_RES_12 = 2'h1;
  localparam logic [1:0] TPC_RES_14 = 2'h2;
  localparam logic [1:0] TPC_RES_16 = 2'h3;

  // ---------------------------------------------------------------------------
  // reset values and timing counts (clk_sys 100 MHz, 10 ns)
  // ---------------------------------------------------------------------------
  localparam logic [15:0] TPC_POS_RST = 16'h0000;
  localparam int unsigned TPC_CLK_NS = 10;
  localparam int unsigned TPC_BUSY_NS = 200;
  localparam int unsigned TPC_BUSY_CYC = (TPC_BUSY_NS + TPC_CLK_NS - 1) / TPC_CLK_NS;
  localparam int unsigned TPC_WRAP_NS = 300;
  localparam int unsigned TPC_WRAP_CYC = (TPC_WRAP_NS + TPC_CLK_NS - 1) / TPC_CLK_NS;
  localparam logic [4:0] TPC_BUSY_LEN = 5'(TPC_BUSY_CYC);
  localparam logic [5:0] TPC_WRAP_LEN = 6'(TPC_WRAP_CYC);

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TPC_IDLE = 2'b00,
    TPC_STEP = 2'b01,
    TPC_BUSY = 2'b10
  } tpc_state_e;

  // step request from the tracking loop
  typedef struct packed {
    logic up;
    logic down;
  } tpc_step_s;

  // bus-side output pins
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] oe_n;
  } tpc_bus_s;

endpackage : tpc_pkg

/* File: verification/tpc_counter_chk.sv */
// checker: port-level assertions for the position counter
module tpc_counter_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controls
  input wire logic resolution_select_low,
  input wire logic resolution_select_high,
  input wire logic latch_hold_n,
  input wire logic output_enable_n,
  input wire logic byte_choice,
  // outputs
  input wire logic busy,
  input wire logic direction,
  input wire logic wrap,
  input wire logic [15:0] position_lines,
  input wire logic [15:0] position_lines_oe_n,
  input wire logic step_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // busy rises two edges after a count change is seen
  sequence s_busy_late;
    ##2 $rose(busy);
  endsequence
  property p_busy_w; $rose(busy) |-> busy[*8]; endproperty
  a_busy_w: assert property (p_busy_w) else $error("busy too short");
  property p_wrap_w; $rose(wrap) |-> wrap[*8]; endproperty
  a_wrap_w: assert property (p_wrap_w) else $error("wrap too short");
  property p_wrap_busy; $rose(wrap) |-> ##1 $rose(busy); endproperty
  a_wrap_busy: assert property (p_wrap_busy) else $error("wrap not before busy");
  property p_dir_wrap; $rose(wrap) |-> $stable(direction); endproperty
  a_dir_wrap: assert property (p_dir_wrap) else $error("direction moved with wrap");
  property p_ready; step_ready |-> !busy; endproperty
  a_ready: assert property (p_ready) else $error("ready while busy");
  property p_dir; $changed(direction) |-> s_busy_late; endproperty
  a_dir: assert property (p_dir) else $error("direction moved without step");
  property p_oe_off; output_enable_n && $past(output_enable_n) |-> &position_lines_oe_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("lines driven while off");
  property p_oe_on;
    !output_enable_n && !$past(output_enable_n) && !$past(rst) |-> position_lines_oe_n == 16'h0000;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("lines not driven");
  property p_dup;
    !byte_choice && !$past(byte_choice) && !$past(rst)
      |-> position_lines[15:8] == position_lines[7:0];
  endproperty
  a_dup: assert property (p_dup) else $error("low byte not duplicated");
  property p_unused;
    {resolution_select_high, resolution_select_low} == 2'h0 && byte_choice && $past(byte_choice)
      && $stable(resolution_select_high) && $stable(resolution_select_low) && !$past(rst)
      |-> position_lines[15:10] == 6'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused lines not low");
  property p_refresh; $rose(latch_hold_n) |-> ##[1:60] $rose(busy); endproperty
  a_refresh: assert property (p_refresh) else $error("no refresh busy");
endmodule // tpc_counter_chk

bind tpc_counter tpc_counter_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .resolution_select_low(resolution_select_low), .resolution_select_high(resolution_select_high),
  .latch_hold_n(latch_hold_n), .output_enable_n(output_enable_n), .byte_choice(byte_choice),
  .busy(busy), .direction(direction), .wrap(wrap), .position_lines(position_lines),
  .position_lines_oe_n(position_lines_oe_n), .step_ready(step_ready));

/* File: verification/tpc_counter_tb_top.sv */
// testbench: directed steps, wraps, hold and bus checks
module tpc_counter_tb_top import tpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, lh_n, oe_n, bc, busy, direction, wrap, rdy, wr;
  logic [1:0] res;
  logic [15:0] pl_o, pl_oe_n, bus, msk;
  tpc_step_s step;
  int n_mismatch = 0;
  int checks = 0;
  tpc_counter dut (.clk_sys(clk_sys), .rst(rst), .step(step), .resolution_select_low(res[0]),
    .resolution_select_high(res[1]), .latch_hold_n(lh_n), .output_enable_n(oe_n),
    .byte_choice(bc), .busy(busy), .direction(direction), .wrap(wrap), .step_ready(rdy),
    .position_lines(pl_o), .position_lines_oe_n(pl_oe_n));
  tpc_host_model host (.clk_sys(clk_sys), .rst(rst), .pl_o(pl_o), .pl_oe_n(pl_oe_n), .bus(bus));
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one step request, then watch wrap while busy runs out
  task automatic stp(input logic up);
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk_sys) #1;
    chk("step_ready", 16'h0001, 16'(rdy));
    step = '{up, !up};
    wr = 0;
    @(posedge clk_sys) #1;
    step = '0;
    repeat (40) begin
      @(posedge clk_sys) #1;
      wr = wr | (wrap === 1'b1);
    end
  endtask
  initial begin
    rst = 1; step = '0; res = 2'h0; lh_n = 1; oe_n = 0; bc = 1;
    repeat (6) @(posedge clk_sys);
    #1 rst = 0;
    chk("dir_rst", 16'h0001, 16'(direction));
    for (int r = 0; r < 4; r++) begin
      res = 2'(r);
      msk = (16'h0001 << (10 + 2 * r)) - 16'h0001;
      stp(0);
      chk("wrap_dn", 16'h0001, 16'(wr));
      chk("dir_dn", 16'h0000, 16'(direction));
      chk("pos_dn", msk, bus);
      bc = 0;
      repeat (3) @(posedge clk_sys) #1;
      chk("pos_lsb", {msk[7:0], msk[7:0]}, bus);
      bc = 1;
      stp(1);
      chk("wrap_up", 16'h0001, 16'(wr));
      chk("dir_up", 16'h0001, 16'(direction));
      chk("pos_up", 16'h0000, bus);
    end
    lh_n = 0;
    stp(0);
    chk("wrap_hold", 16'h0001, 16'(wr));
    chk("dir_hold", 16'h0000, 16'(direction));
    chk("pos_hold", 16'h0000, bus);
    lh_n = 1;
    repeat (40) @(posedge clk_sys) #1;
    chk("pos_rel", 16'hffff, bus);
    stp(0);
    chk("wrap_none", 16'h0000, 16'(wr));
    chk("dir_keep", 16'h0000, 16'(direction));
    chk("pos_step", 16'hfffe, bus);
    oe_n = 1;
    repeat (2) @(posedge clk_sys) #1;
    chk("oe_off", 16'hffff, pl_oe_n);
    chk("bus_off", 16'h0001, bus);
    complete_run();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end
endmodule // tpc_counter_tb_top

/* File: verification/tpc_host_model.sv */
// host model: resolves the position lines as the far bus sees them
module tpc_host_model (
  // clock, reset and pins
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] pl_o,
  input wire logic [15:0] pl_oe_n,
  // resolved bus
  output logic [15:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last_q;
  // released lines show the inverse of their last driven level
  always_comb bus = (pl_o & ~pl_oe_n) | (~last_q & pl_oe_n);
  // remember the last driven level of each line
  always_ff @(posedge clk_sys) last_q <= rst ? 16'h0000 : (pl_o & ~pl_oe_n) | (last_q & pl_oe_n);
endmodule // tpc_host_model
